// *** core/sdpi_mem_ctl.sv ***
// memory controller end: makes the link clock, sends commands and data
`timescale 1ns/100ps
`default_nettype none
module sdpi_mem_ctl import sdpi_pkg::*; #(
    parameter bit WIDE = 1'b1,
    parameter int ADDR_W = 4,
    parameter int CLK_HALF = CLK_HALF_CYC
) (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    sdpi_link_if.ctl link, // pins toward the device
    input wire logic power_down, // level: request power-down
    input wire logic req_valid, // request present
    output logic req_ready, // request taken this cycle
    input wire logic req_write, // 1 write, 0 read
    input wire logic [ADDR_W-2:0] req_addr, // burst address
    input wire logic [2*DQ_MAX-1:0] req_wdata, // beat1:beat0
    input wire logic [2*LANES_MAX-1:0] req_wmask, // beat1:beat0, 1 skips byte
    output logic rsp_valid, // read data pulse
    output logic [2*DQ_MAX-1:0] rsp_rdata, // beat1:beat0
    output logic pd_active // clock enable held low
);
    // ================================================================
    // configuration
    localparam int DQ_W = WIDE ? DQ_MAX : DQ_MAX / 2;
    localparam int LANES = DQ_W / BYTE_W;
    localparam logic [7:0] PH_LAST = 8'(2 * CLK_HALF - 1);
    localparam logic [7:0] PH_HALF = 8'(CLK_HALF);
    localparam logic [7:0] PH_Q1 = 8'(CLK_HALF / 2);
    localparam logic [7:0] PH_Q3 = 8'(CLK_HALF + CLK_HALF / 2);
    localparam logic [LANES_MAX-1:0] LANE_EN = LANES_MAX'((1 << LANES) - 1);
    localparam logic [DQ_MAX-1:0] DQ_EN = DQ_MAX'((64'h1 << DQ_W) - 64'h1);

    typedef struct packed {
        sdpi_ctl_state_e state;
        logic [7:0] ph;
        logic ck;
        logic cke;
        logic cs_n;
        logic [CA_W-1:0] ca;
        logic wr;
        logic [ADDR_W-2:0] addr;
        logic [2*DQ_MAX-1:0] wdata;
        logic [2*LANES_MAX-1:0] wmask;
        logic [DQ_MAX-1:0] dq_o;
        logic [LANES_MAX-1:0] dm;
        logic drv;
        logic dqs_o;
        logic [7:0] cnt;
        logic dqs_s1;
        logic dqs_s2;
        logic dqs_p;
        logic [DQ_MAX-1:0] dq_s1;
        logic [DQ_MAX-1:0] dq_s2;
        logic [7:0] smp;
        logic beat;
        logic [2*DQ_MAX-1:0] rdata;
        logic rsp;
    } sdpi_ctl_s;

    sdpi_ctl_s q;
    sdpi_ctl_s d;
    logic present;

    // new pin values are set mid-way between clock edges for margin
    assign present = q.ph == PH_Q3;
    // a command waits one link period after power-down exit, never rides the enable edge
    assign req_ready = (q.state == CS_IDLE) && present && !power_down && q.cke;

    always_comb begin
        d = q;
        d.rsp = 1'b0;
        d.ph = (q.ph == PH_LAST) ? 8'h00 : q.ph + 8'h01;
        d.ck = d.ph < PH_HALF;
        d.dqs_s1 = link.dqs_t[0];
        d.dqs_s2 = q.dqs_s1;
        d.dqs_p = q.dqs_s2;
        d.dq_s1 = link.dq;
        d.dq_s2 = q.dq_s1;
        if (present) begin
            d.cs_n = 1'b1;
            d.ca = '0;
        end
        case (q.state)
            CS_IDLE: begin
                if (present) begin
                    d.cke = !power_down;
                end
                if (req_ready && req_valid) begin
                    d.cs_n = 1'b0;
                    d.ca = CA_W'(req_write ? OP_WRITE : OP_READ);
                    d.wr = req_write;
                    d.addr = req_addr;
                    d.wdata = req_wdata;
                    d.wmask = req_wmask;
                    d.state = CS_CMD;
                end
            end
            CS_CMD: begin
                if (q.ph == PH_Q1) begin
                    d.ca = CA_W'(q.addr);
                    d.state = CS_ADR;
                end
            end
            CS_ADR: begin
                if (present) begin
                    d.cnt = '0;
                    d.beat = 1'b0;
                    d.smp = '0;
                    d.state = q.wr ? CS_WR : CS_RD;
                    if (q.wr) begin
                        d.drv = 1'b1;
                        d.dqs_o = 1'b0;
                        d.dq_o = q.wdata[DQ_MAX-1:0] & DQ_EN;
                        d.dm = q.wmask[LANES_MAX-1:0] & LANE_EN;
                    end
                end
            end
            CS_WR: begin
                d.cnt = q.cnt + 8'h01;
                if (q.cnt == STB_GAP_CYC) begin
                    d.dqs_o = 1'b1;
                end else if (q.cnt == 8'(2 * STB_GAP_CYC)) begin
                    d.dq_o = q.wdata[2*DQ_MAX-1:DQ_MAX] & DQ_EN;
                    d.dm = q.wmask[2*LANES_MAX-1:LANES_MAX] & LANE_EN;
                end else if (q.cnt == 8'(3 * STB_GAP_CYC)) begin
                    d.dqs_o = 1'b0;
                end else if (q.cnt == 8'(4 * STB_GAP_CYC)) begin
                    d.drv = 1'b0;
                    d.dm = '0;
                    d.state = CS_IDLE;
                end
            end
            CS_RD: begin
                // read data changes with the strobe, so sample half a beat (4 cycles) later
                if (q.dqs_s2 != q.dqs_p) begin
                    d.smp = RD_SAMPLE_CYC;
                end else if (q.smp != 8'h00) begin
                    d.smp = q.smp - 8'h01;
                end
                if (q.smp == 8'h01) begin
                    d.beat = 1'b1;
                    if (q.beat) begin
                        d.rdata[2*DQ_MAX-1:DQ_MAX] = q.dq_s2 & DQ_EN;
                        d.rsp = 1'b1;
                        d.state = CS_IDLE;
                    end else begin
                        d.rdata[DQ_MAX-1:0] = q.dq_s2 & DQ_EN;
                    end
                end
            end
            default: begin
                d.state = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.state <= CS_IDLE;
            q.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ================================================================
    // pins
    assign link.clock_true = q.ck;
    assign link.clock_complement = !q.ck;
    assign link.cke = q.cke;
    assign link.cs_n = q.cs_n;
    assign link.cmd_addr_bus = q.ca;
    assign link.write_byte_mask = q.dm;
    assign link.dq_ctl_o = q.dq_o;
    assign link.dq_ctl_oe = q.drv;
    assign link.dqs_t_ctl_o = {LANES_MAX{q.dqs_o}} & LANE_EN;
    assign link.dqs_c_ctl_o = {LANES_MAX{!q.dqs_o}} & LANE_EN;
    assign link.dqs_ctl_oe = q.drv;
    assign rsp_valid = q.rsp;
    assign rsp_rdata = q.rdata;
    assign pd_active = !q.cke;
endmodule
`default_nettype wire

// *** core/sdpi_mem_dev.sv ***
// sdram device end: samples the pins, stores and returns data
`timescale 1ns/100ps
`default_nettype none
module sdpi_mem_dev import sdpi_pkg::*; #(
    parameter bit WIDE = 1'b1,
    parameter int ADDR_W = 4
) (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    sdpi_link_if.dev link, // pins toward the controller
    output logic pd_active, // device in power-down
    output logic wr_done, // write burst stored
    output logic rd_done // read burst sent
);
    // ================================================================
    // configuration
    localparam int DQ_W = WIDE ? DQ_MAX : DQ_MAX / 2;
    localparam int LANES = DQ_W / BYTE_W;
    localparam int DEPTH = 2 ** ADDR_W;
    localparam logic [7:0] RD_B1_CYC = RD_PRE_CYC + RD_BEAT_CYC;
    localparam logic [7:0] RD_END_CYC = RD_PRE_CYC + RD_BEAT_CYC + RD_BEAT_CYC;

    typedef struct packed {
        sdpi_dev_state_e state;
        logic ckt_s1;
        logic ckt_s2;
        logic ckc_s1;
        logic ckc_s2;
        logic ck_hi;
        logic cs_n_s1;
        logic cs_n_s2;
        logic cke_s1;
        logic cke_s2;
        logic [CA_W-1:0] ca_s1;
        logic [CA_W-1:0] ca_s2;
        logic [DQ_MAX-1:0] dq_s1;
        logic [DQ_MAX-1:0] dq_s2;
        logic [LANES_MAX-1:0] dm_s1;
        logic [LANES_MAX-1:0] dm_s2;
        logic dqs_s1;
        logic dqs_s2;
        logic dqs_p;
        logic [OP_W-1:0] op;
        logic [ADDR_W-2:0] addr;
        logic beat;
        logic [7:0] cnt;
        logic [DQ_W-1:0] dq_o;
        logic drv;
        logic dqs_o;
        logic pd;
        logic wr_done;
        logic rd_done;
    } sdpi_dev_s;

    sdpi_dev_s q;
    sdpi_dev_s d;
    logic [DQ_W-1:0] mem [DEPTH];
    logic mem_we;
    logic [ADDR_W-1:0] mem_idx;
    logic ck_rise;
    logic ck_fall;
    logic dqs_edge;
    logic cmd_valid;

    // ================================================================
    // edge finding on the synchronised link clock
    always_comb begin
        ck_rise = q.ckt_s2 && !q.ckc_s2 && !q.ck_hi;
        ck_fall = !q.ckt_s2 && q.ckc_s2 && q.ck_hi;
        // all lanes move together, so lane 0 stands for every strobe
        dqs_edge = q.dqs_s2 != q.dqs_p;
        cmd_valid = q.cke_s2 && !q.cs_n_s2;
    end

    // ================================================================
    // next state
    always_comb begin
        d = q;
        d.wr_done = 1'b0;
        d.rd_done = 1'b0;
        mem_we = 1'b0;
        mem_idx = {q.addr, q.beat};
        d.ckt_s1 = link.clock_true;
        d.ckt_s2 = q.ckt_s1;
        d.ckc_s1 = link.clock_complement;
        d.ckc_s2 = q.ckc_s1;
        d.cs_n_s1 = link.cs_n;
        d.cs_n_s2 = q.cs_n_s1;
        d.cke_s1 = link.cke;
        d.cke_s2 = q.cke_s1;
        d.ca_s1 = link.cmd_addr_bus;
        d.ca_s2 = q.ca_s1;
        d.dq_s1 = link.dq;
        d.dq_s2 = q.dq_s1;
        d.dm_s1 = link.write_byte_mask;
        d.dm_s2 = q.dm_s1;
        d.dqs_s1 = link.dqs_t[0];
        d.dqs_s2 = q.dqs_s1;
        d.dqs_p = q.dqs_s2;
        if (ck_rise) begin
            d.ck_hi = 1'b1;
        end else if (ck_fall) begin
            d.ck_hi = 1'b0;
        end
        if (ck_rise) begin
            d.pd = !q.cke_s2;
        end
        case (q.state)
            DS_IDLE: begin
                if (ck_rise && cmd_valid) begin
                    d.op = q.ca_s2[OP_W-1:0];
                    if (q.ca_s2[OP_W-1:0] == OP_WRITE || q.ca_s2[OP_W-1:0] == OP_READ) begin
                        d.state = DS_CMD;
                    end
                end
            end
            DS_CMD: begin
                if (ck_fall) begin
                    // column bit zero is the beat number, upper bus bits ignored
                    d.addr = q.ca_s2[ADDR_W-2:0];
                    d.beat = 1'b0;
                    d.cnt = '0;
                    d.state = (q.op == OP_WRITE) ? DS_WR : DS_RD;
                end
            end
            DS_WR: begin
                if (dqs_edge) begin
                    mem_we = 1'b1;
                    d.beat = !q.beat;
                    if (q.beat) begin
                        d.wr_done = 1'b1;
                        d.state = DS_IDLE;
                    end
                end
            end
            DS_RD: begin
                d.drv = 1'b1;
                d.cnt = q.cnt + 8'h01;
                if (q.cnt == RD_PRE_CYC) begin
                    d.dqs_o = 1'b1;
                    d.dq_o = mem[{q.addr, 1'b0}];
                end else if (q.cnt == RD_B1_CYC) begin
                    d.dqs_o = 1'b0;
                    d.dq_o = mem[{q.addr, 1'b1}];
                end else if (q.cnt == RD_END_CYC) begin
                    d.drv = 1'b0;
                    d.rd_done = 1'b1;
                    d.state = DS_IDLE;
                end
            end
            default: begin
                d.state = DS_IDLE;
            end
        endcase
        // clock enable low at a rising edge stops the burst and the drivers
        if (ck_rise && !q.cke_s2) begin
            d.state = DS_IDLE;
            d.drv = 1'b0;
            d.dqs_o = 1'b0;
            mem_we = 1'b0;
        end
    end

    // ================================================================
    // registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
            q.state <= DS_IDLE;
            q.cs_n_s1 <= 1'b1;
            q.cs_n_s2 <= 1'b1;
            q.ckc_s1 <= 1'b1;
            q.ckc_s2 <= 1'b1;
            q.pd <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // storage holds no reset: contents are undefined until written
    always_ff @(posedge clock) begin
        if (mem_we) begin
            for (int l = 0; l < LANES; l++) begin
                if (!q.dm_s2[l]) begin
                    mem[mem_idx][l*BYTE_W +: BYTE_W] <= q.dq_s2[l*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    // ================================================================
    // pin drive per byte lane
    for (genvar l = 0; l < LANES_MAX; l++) begin : g_lane
        if (l < LANES) begin : g_used
            assign link.dq_dev_o[l*BYTE_W +: BYTE_W] = q.dq_o[l*BYTE_W +: BYTE_W];
            assign link.dqs_t_dev_o[l] = q.dqs_o;
            assign link.dqs_c_dev_o[l] = !q.dqs_o;
        end else begin : g_unused
            assign link.dq_dev_o[l*BYTE_W +: BYTE_W] = '0;
            assign link.dqs_t_dev_o[l] = 1'b0;
            assign link.dqs_c_dev_o[l] = 1'b0;
        end
    end

    assign link.dq_dev_oe = q.drv;
    assign link.dqs_dev_oe = q.drv;
    assign pd_active = q.pd;
    assign wr_done = q.wr_done;
    assign rd_done = q.rd_done;
endmodule
`default_nettype wire

// *** inc/sdpi_link_if.sv ***
// pin-level link between memory controller and sdram device
`timescale 1ns/100ps
`default_nettype none
interface sdpi_link_if import sdpi_pkg::*; ();
    logic clock_true;
    logic clock_complement;
    logic cke;
    logic cs_n;
    logic [CA_W-1:0] cmd_addr_bus;
    logic [LANES_MAX-1:0] write_byte_mask;
    logic [DQ_MAX-1:0] dq_ctl_o;
    logic dq_ctl_oe;
    logic [DQ_MAX-1:0] dq_dev_o;
    logic dq_dev_oe;
    logic [LANES_MAX-1:0] dqs_t_ctl_o;
    logic [LANES_MAX-1:0] dqs_c_ctl_o;
    logic dqs_ctl_oe;
    logic [LANES_MAX-1:0] dqs_t_dev_o;
    logic [LANES_MAX-1:0] dqs_c_dev_o;
    logic dqs_dev_oe;
    logic [DQ_MAX-1:0] dq;
    logic [LANES_MAX-1:0] dqs_t;
    logic [LANES_MAX-1:0] dqs_c;

    // released data and true strobe read as zero, complement strobe as one; device wins if both ever drive
    assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
    assign dqs_t = dqs_dev_oe ? dqs_t_dev_o : (dqs_ctl_oe ? dqs_t_ctl_o : '0);
    assign dqs_c = dqs_dev_oe ? dqs_c_dev_o : (dqs_ctl_oe ? dqs_c_ctl_o : '1);

    modport dev (
        input clock_true, clock_complement, cke, cs_n, cmd_addr_bus, write_byte_mask, dq, dqs_t, dqs_c,
        output dq_dev_o, dq_dev_oe, dqs_t_dev_o, dqs_c_dev_o, dqs_dev_oe
    );
    modport ctl (
        input dq, dqs_t, dqs_c,
        output clock_true, clock_complement, cke, cs_n, cmd_addr_bus, write_byte_mask,
        output dq_ctl_o, dq_ctl_oe, dqs_t_ctl_o, dqs_c_ctl_o, dqs_ctl_oe
    );
endinterface
`default_nettype wire

// *** inc/sdpi_pkg.sv ***
// constants and types shared by both ends of the sdram pin link
// ====================================================================
// What this block does
// - command/address bus captured on both clock edges
// - chip select, clock enable sampled at rising edge
// - rising edge: true rises, complement falls
// - clock enable low stops inputs and drivers
// - power saving entered/left only by clock enable
// - command formed from enable, select and bus
// - strobe driven by whoever drives the data
// - read strobe edge aligned, write strobe centred
// - one strobe pair per data byte lane
// - masked bytes are not written
// - mask sampled on both strobe edges
// - mask is input only, one per lane
// - column bit zero implied zero, unused ignored
// - narrow mode leaves upper lanes unused
package sdpi_pkg;
    // ================================================================
    // widths
    localparam int DQ_MAX = 32;
    localparam int LANES_MAX = 4;
    localparam int BYTE_W = 8;
    localparam int CA_W = 10;
    localparam int OP_W = 2;

    // ================================================================
    // command opcodes carried in the rising half of the bus
    localparam logic [OP_W-1:0] OP_NOP = 2'h0;
    localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
    localparam logic [OP_W-1:0] OP_READ = 2'h2;

    // ================================================================
    // cycle counts on the 100 MHz system clock
    localparam int CLK_HALF_CYC = 6;
    localparam logic [7:0] STB_GAP_CYC = 8'h06;
    localparam logic [7:0] RD_PRE_CYC = 8'h04;
    localparam logic [7:0] RD_BEAT_CYC = 8'h08;
    localparam logic [7:0] RD_SAMPLE_CYC = 8'h04;

    // ================================================================
    // states
    typedef enum logic [3:0] {
        DS_IDLE = 4'h1,
        DS_CMD = 4'h2,
        DS_WR = 4'h4,
        DS_RD = 4'h8
    } sdpi_dev_state_e;

    typedef enum logic [4:0] {
        CS_IDLE = 5'h01,
        CS_CMD = 5'h02,
        CS_ADR = 5'h04,
        CS_WR = 5'h08,
        CS_RD = 5'h10
    } sdpi_ctl_state_e;
endpackage

// *** tb/sdpi_link_chk.sv ***
// checker for the pins between the controller and device ends
`timescale 1ns/100ps
`default_nettype none
module sdpi_link_chk import sdpi_pkg::*; (
    input wire logic clock, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic clock_true, // link clock
    input wire logic clock_complement, // link clock, inverse
    input wire logic cke, // clock enable
    input wire logic cs_n, // select, active low
    input wire logic [CA_W-1:0] cmd_addr_bus, // command/address
    input wire logic [LANES_MAX-1:0] write_byte_mask, // byte skip
    input wire logic [DQ_MAX-1:0] dq, // resolved data
    input wire logic dq_ctl_oe, // controller drives data
    input wire logic dq_dev_oe, // device drives data
    input wire logic [LANES_MAX-1:0] dqs_t, // resolved strobe
    input wire logic [LANES_MAX-1:0] dqs_c, // resolved strobe, inverse
    input wire logic dqs_ctl_oe, // controller drives strobe
    input wire logic dqs_dev_oe // device drives strobe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // ====================================================================
    // command pins
    diff_clock_a: assert property (clock_complement == ~clock_true)
        else $error("link clock pair not complementary");
    bus_off_edge_a: assert property ($changed(clock_true) |-> $stable(cmd_addr_bus))
        else $error("command bus moved on a link clock edge");
    sdr_low_half_a: assert property ($changed({cs_n, cke}) |-> !clock_true ##1 !clock_true)
        else $error("select or enable moved near a rising edge");
    cmd_needs_cke_a: assert property (!cs_n |-> cke)
        else $error("command issued with clock enable low");
    cke_no_cmd_a: assert property ($changed(cke) |-> cs_n)
        else $error("clock enable moved during a command");
    pd_quiet_a: assert property (!cke && $rose(clock_true) |-> ##6 !(dq_dev_oe || dqs_dev_oe))
        else $error("device drives while clock enable low");

    // ====================================================================
    // data and strobe pins
    one_driver_a: assert property (!((dq_ctl_oe || dqs_ctl_oe) && (dq_dev_oe || dqs_dev_oe)))
        else $error("both ends drive data or strobe");
    strobe_with_data_a: assert property (dq_ctl_oe == dqs_ctl_oe && dq_dev_oe == dqs_dev_oe)
        else $error("strobe enable differs from data enable");
    lanes_equal_a: assert property ((dqs_ctl_oe || dqs_dev_oe) |-> dqs_t == {4{dqs_t[0]}} && dqs_c == ~dqs_t)
        else $error("strobe lanes disagree");
    wr_centred_a: assert property (dqs_ctl_oe && $past(dqs_ctl_oe) && $changed(dqs_t[0])
        |-> $stable({dq, write_byte_mask}) ##1 $stable({dq, write_byte_mask})[*3])
        else $error("write data not centred on strobe");
    rd_aligned_a: assert property (dq_dev_oe && $past(dq_dev_oe) && $changed(dq) |-> $changed(dqs_t[0]))
        else $error("read data moved without strobe edge");
endmodule
`default_nettype wire

// *** tb/sdpi_tb_top.sv ***
// self-checking bench joining controller and device ends
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_interface_tb_top import sdpi_pkg::*;;
    logic clock;
    logic reset_n;
    logic power_down;
    logic req_valid;
    logic req_ready;
    logic req_write;
    logic [2:0] req_addr;
    logic [2*DQ_MAX-1:0] req_wdata;
    logic [2*LANES_MAX-1:0] req_wmask;
    logic rsp_valid;
    logic [2*DQ_MAX-1:0] rsp_rdata;
    logic ctl_pd;
    logic dev_pd;
    logic wr_done;
    logic rd_done;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 32'h59234b30;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int wr_seen = 0;
    int rd_seen = 0;
    logic dqs_prev = 1'b0;
    logic [63:0] shadow [8];
    logic [63:0] rq [$];
    logic [63:0] wq [$];

    sdpi_link_if link ();
    sdpi_mem_dev #(.WIDE(1'b1), .ADDR_W(4)) sdpi_mem_dev_inst (.clock(clock), .reset_n(reset_n), .link(link),
        .pd_active(dev_pd), .wr_done(wr_done), .rd_done(rd_done));
    sdpi_mem_ctl #(.WIDE(1'b1), .ADDR_W(4), .CLK_HALF(CLK_HALF_CYC)) sdpi_mem_ctl_inst (.clock(clock),
        .reset_n(reset_n), .link(link), .power_down(power_down), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_wmask(req_wmask),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pd_active(ctl_pd));
    sdpi_link_chk sdpi_link_chk_inst (.clock(clock), .reset_n(reset_n), .clock_true(link.clock_true),
        .clock_complement(link.clock_complement), .cke(link.cke), .cs_n(link.cs_n),
        .cmd_addr_bus(link.cmd_addr_bus), .write_byte_mask(link.write_byte_mask), .dq(link.dq),
        .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe), .dqs_t(link.dqs_t), .dqs_c(link.dqs_c),
        .dqs_ctl_oe(link.dqs_ctl_oe), .dqs_dev_oe(link.dqs_dev_oe));

    // ====================================================================
    // shared tasks
    task automatic check_val(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // held until taken; expectations noted at the taking edge
    task automatic do_req(input logic w, input logic [2:0] a, input logic [63:0] d, input logic [7:0] m);
        int i;
        i = 0;
        @(negedge clock);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_wmask = m;
        #1;
        while (req_ready !== 1'b1 && i < 400) begin
            @(negedge clock);
            #1;
            i++;
        end
        if (i == 400) begin
            error_cnt++;
            $display("BAD %0t: request never taken", $time);
        end
        @(posedge clock);
        if (w) begin
            wr_cnt++;
            wq.push_back({28'h0000000, m[3:0], d[31:0]});
            wq.push_back({28'h0000000, m[7:4], d[63:32]});
            for (int b = 0; b < 8; b++) begin
                if (!m[b]) begin
                    shadow[a][8*b+:8] = d[8*b+:8];
                end
            end
        end else begin
            rd_cnt++;
            rq.push_back(shadow[a]);
        end
        @(negedge clock);
        req_valid = 1'b0;
    endtask

    // ====================================================================
    // watchers
    always @(negedge clock) begin
        if (link.dqs_ctl_oe === 1'b1 && link.dqs_t[0] !== dqs_prev) begin
            if (wq.size() == 0) begin
                check_val(64'h1, 64'h0);
            end else begin
                check_val({28'h0000000, link.write_byte_mask, link.dq}, wq.pop_front());
            end
        end
        dqs_prev = link.dqs_t[0];
        if (rsp_valid === 1'b1) begin
            if (rq.size() == 0) begin
                check_val(64'h1, 64'h0);
            end else begin
                check_val(rsp_rdata, rq.pop_front());
            end
        end
        if (wr_done === 1'b1) begin
            wr_seen++;
        end
        if (rd_done === 1'b1) begin
            rd_seen++;
        end
    end

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // a full run is about fifteen hundred cycles
    initial begin
        #400000;
        error_cnt++;
        $display("BAD %0t: watchdog expired", $time);
        give_verdict();
    end

    // ====================================================================
    // main sequence
    initial begin
        reset_n = 1'b0;
        power_down = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 3'h0;
        req_wdata = 64'h0;
        req_wmask = 8'h00;
        repeat (5) @(posedge clock);
        @(negedge clock);
        check_val({63'h0, dev_pd}, 64'h1);
        reset_n = 1'b1;
        // device memory starts unknown, so every word is written whole first
        for (int a = 0; a < 8; a++) begin
            do_req(1'b1, a[2:0], {$random(seed), $random(seed)}, 8'h00);
        end
        for (int a = 7; a >= 0; a--) begin
            do_req(1'b0, a[2:0], 64'h0, 8'h00);
        end
        repeat (6) begin
            req_addr = 3'($random(seed));
            do_req(1'b1, req_addr, {$random(seed), $random(seed)}, 8'($random(seed)));
            do_req(1'b0, req_addr, 64'h0, 8'h00);
        end
        do_req(1'b1, 3'h5, 64'h0, 8'hff);
        repeat (60) @(negedge clock);
        power_down = 1'b1;
        repeat (40) @(negedge clock);
        check_val({63'h0, link.cke}, 64'h0);
        check_val({62'h0, ctl_pd, dev_pd}, 64'h3);
        fork
            do_req(1'b0, 3'h5, 64'h0, 8'h00);
            begin
                repeat (40) @(negedge clock);
                check_val({63'h0, req_ready}, 64'h0);
                power_down = 1'b0;
            end
        join
        repeat (120) @(negedge clock);
        check_val({62'h0, ctl_pd, dev_pd}, 64'h0);
        check_val(64'(rq.size() + wq.size()), 64'h0);
        check_val(64'(wr_seen), 64'(wr_cnt));
        check_val(64'(rd_seen), 64'(rd_cnt));
        give_verdict();
    end
endmodule
`default_nettype wire
